// File: blgd_consts.vh
// constants for the battery led gauge display block
`ifndef BLGD_CONSTS_VH
`define BLGD_CONSTS_VH
// timing: clock period, one millisecond, one second
`define BLGD_CLK_NS       4
`define BLGD_MS_NS        1000000
`define BLGD_S_MS         20'd1000
// register byte offsets
`define BLGD_CFG          6'h00
`define BLGD_CMD          6'h04
`define BLGD_RATE         6'h08
`define BLGD_TIME         6'h0C
`define BLGD_ALARM        6'h10
`define BLGD_DTHR         6'h14
`define BLGD_CTHR         6'h18
`define BLGD_THR5         6'h1C
`define BLGD_STATE        6'h20
// cfg field positions
`define BLGD_CFG_CNT_LO   0
`define BLGD_CFG_CNT_HI   1
`define BLGD_CFG_SERIES   2
`define BLGD_CFG_SRC      3
`define BLGD_CFG_RCAEN    4
`define BLGD_CFG_SHOW_AFTER_RESET     5
`define BLGD_CFG_SHOW_WHILE_CHARGING   6
`define BLGD_CFG_PFEN     7
`define BLGD_CFG_PFNOHOLD 8
`define BLGD_CMD_SHOW     0
// reset values: five segments, show after reset, 500/1000 ms, 100 ms, 4 s, 10 %
`define BLGD_CFG_RST      32'h0000_0023
`define BLGD_RATE_RST     32'h03E8_01F4
`define BLGD_TIME_RST     32'h0004_0064
`define BLGD_ALARM_RST    32'h0000_0A0A
`define BLGD_PCT_MAX      8'h65
// fixed threshold tables, segment 1 in the low byte
`define BLGD_FIX3         40'hFF_FF_43_22_00
`define BLGD_FIX4         40'hFF_4B_32_19_00
`define BLGD_FIX5         40'h50_3C_28_14_00
// count selector codes
`define BLGD_CNT_USER     2'b00
`define BLGD_CNT_3        2'b01
`define BLGD_CNT_4        2'b10
// states
`define BLGD_ST_IDLE      2'h0
`define BLGD_ST_STEP      2'h1
`define BLGD_ST_HOLD      2'h2
`define BLGD_ST_FAIL      2'h3
// axi responses
`define BLGD_RESP_OKAY    2'h0
`define BLGD_RESP_SLVERR  2'h2
`endif

// File: blgd_display.v
// led capacity display controller with axi4-lite register slave
`timescale 1ns/1ps
// How it works
// - count selector: 00 user thresholds, 01 three, 10 four, 11 five segments.
// - thresholds loaded per segment count at reset and on each cfg write that selects a fixed count.
// - series selector 0: each segment driven on its own.
// - series selector 1: shunt nodes to ground, no failure display.
// - source selector picks relative (0) or absolute (1) charge percentage.
// - discharging: segment lit when percentage at or above discharge threshold.
// - at or below discharge alarm level lit segments flash, half duty.
// - alarm flash enable with capacity alarm flashes lit segments, half duty.
// - user thresholds kept within 0 to 101 percent.
// - charging: segment lit when percentage at or above charge threshold.
// - charging: highest lit segment blinks at blink rate.
// - at or below charge alarm level lit segments flash, half duty.
// - permanent fail flag shows failure code format.
// - segment three blinks for first eight causes, else segment two.
// - segments switch on one by one with step delay between.
// - all lit, display held for hold time then all off together.
// - host command or reset exit (if enabled) activates display.
// - charge current above threshold keeps display active if enabled.
// - request pin falling edge activates; further edges ignored until the display is idle again.
// - failure display follows, two hold periods per set cause bit.
// - without no-hold, pin must stay low through hold for failure display.
// - either undervoltage flag blanks the display.
`include "blgd_consts.vh"
module blgd_display #(
	parameter MS_CYCLES = `BLGD_MS_NS / `BLGD_CLK_NS
) (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write
	input  wire [5:0]  awaddr,
	input  wire        awvalid,
	output wire        awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output wire        wready,
	output wire [1:0]  bresp,
	output wire        bvalid,
	input  wire        bready,
	// axi4-lite read
	input  wire [5:0]  araddr,
	input  wire        arvalid,
	output wire        arready,
	output wire [31:0] rdata,
	output wire [1:0]  rresp,
	output wire        rvalid,
	input  wire        rready,
	// gauge state, same clock
	input  wire [7:0]  relative_charge,
	input  wire [7:0]  absolute_charge,
	input  wire        discharging_flag,
	input  wire        remaining_capacity_alarm,
	input  wire        permanent_fail_flag,
	input  wire [15:0] fail_cause_word,
	input  wire        cell_undervoltage_flag,
	input  wire        pack_undervoltage_flag,
	input  wire        charge_current_high,
	// push-button pin, asynchronous
	input  wire        display_request_pin,
	// segment drive
	output wire [4:0]  segment_drive,
	output wire        display_busy
);
	localparam integer MS_LAST_I = MS_CYCLES - 1;
	localparam [17:0]  MS_LAST   = MS_LAST_I[17:0];
	localparam [31:0]  CFG_RST   = `BLGD_CFG_RST;

	reg        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	reg [1:0]  bresp_ff, rresp_ff;
	reg [31:0] rdata_ff, wdata_ff;
	reg [3:0]  wstrb_ff;
	reg [5:0]  waddr_ff;
	reg [31:0] cfg_ff, rate_ff, time_ff, alarm_ff;
	reg [7:0]  dsg_thr_ff [0:4];
	reg [7:0]  chg_thr_ff [0:4];
	reg        show_cmd_ff, first_ff;
	reg        pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_lvl_ff;
	reg [17:0] ms_cnt_ff;
	reg        ms_tick_ff;
	reg [15:0] ph_cnt_ff [0:1];
	reg [1:0]  phase_ff;
	reg [1:0]  state_ff;
	reg [2:0]  step_ff;
	reg [19:0] tmr_ff;
	reg        pin_act_ff, pin_held_ff;
	reg [15:0] pf_rem_ff;
	reg [4:0]  seg_ff;
	reg        busy_ff;
	reg [31:0] rd_mux;
	reg [4:0]  shown;
	reg [4:0]  base;

	assign awready       = awready_ff;
	assign wready        = wready_ff;
	assign bvalid        = bvalid_ff;
	assign bresp         = bresp_ff;
	assign arready       = arready_ff;
	assign rvalid        = rvalid_ff;
	assign rdata         = rdata_ff;
	assign rresp         = rresp_ff;
	assign segment_drive = seg_ff;
	assign display_busy  = busy_ff;

	// byte-lane merge of a write into an old word
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (strb[k])
					merge[k*8 +: 8] = nw[k*8 +: 8];
		end
	endfunction

	// fixed threshold for segment idx under a count code
	function [7:0] thr_fixed;
		input [1:0] code;
		input [2:0] idx;
		reg   [39:0] tbl;
		begin
			case (code)
				`BLGD_CNT_3: tbl = `BLGD_FIX3;
				`BLGD_CNT_4: tbl = `BLGD_FIX4;
				default:     tbl = `BLGD_FIX5;
			endcase
			thr_fixed = tbl[{idx, 3'b000} +: 8];
		end
	endfunction

	// index of lowest set cause bit plus one, zero when none
	function [4:0] cause_idx;
		input [15:0] w;
		integer k;
		reg [4:0] n;
		begin
			cause_idx = 5'h00;
			n = 5'h10;
			for (k = 15; k >= 0; k = k - 1) begin
				if (w[k])
					cause_idx = n;
				n = n - 5'h01;
			end
		end
	endfunction

	// failure code pattern: one segment blinks, two others off/on/flash
	function [4:0] pf_pattern;
		input [4:0] idx;
		input       fl;
		input       bl;
		reg   [4:0] m, r, q;
		reg         lr, lq;
		begin
			m  = (idx < 5'h09) ? idx : idx - 5'h09;
			r  = m % 5'h03;
			q  = m / 5'h03;
			lr = (r == 5'h01) | ((r == 5'h02) & fl);
			lq = (q == 5'h01) | ((q == 5'h02) & fl);
			if (idx < 5'h09)
				pf_pattern = {2'b00, bl, lr, lq};
			else
				pf_pattern = {2'b00, lr, bl, lq};
		end
	endfunction

	// configuration fields
	wire [1:0] cnt_code  = {cfg_ff[`BLGD_CFG_CNT_HI], cfg_ff[`BLGD_CFG_CNT_LO]};
	wire       series    = cfg_ff[`BLGD_CFG_SERIES];
	wire [2:0] nseg      = (cnt_code == `BLGD_CNT_3) ? 3'h3 :
	                       (cnt_code == `BLGD_CNT_4) ? 3'h4 : 3'h5;
	wire [7:0] pct       = cfg_ff[`BLGD_CFG_SRC] ? absolute_charge : relative_charge;
	wire       uv_block  = cell_undervoltage_flag | pack_undervoltage_flag;
	wire       flash_ph  = phase_ff[0];
	wire       blink_ph  = phase_ff[1];

	// write happens once both address and data are caught
	wire       do_write  = ~awready_ff & ~wready_ff & ~bvalid_ff;
	wire [31:0] cfg_new  = merge(cfg_ff, wdata_ff, wstrb_ff);
	wire       wr_cfg    = do_write & (waddr_ff == `BLGD_CFG);
	wire       reload    = wr_cfg & ({cfg_new[`BLGD_CFG_CNT_HI], cfg_new[`BLGD_CFG_CNT_LO]}
	                       != `BLGD_CNT_USER);
	wire       user_wr   = do_write & (cnt_code == `BLGD_CNT_USER);
	wire       mapped_w  = (waddr_ff <= `BLGD_THR5);

	// axi write channel handshakes
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `BLGD_RESP_OKAY;
			waddr_ff   <= 6'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
		end else begin
			if (awvalid && awready_ff) begin
				waddr_ff   <= {awaddr[5:2], 2'b00};
				awready_ff <= 1'b0;
			end
			if (wvalid && wready_ff) begin
				wdata_ff  <= wdata;
				wstrb_ff  <= wstrb;
				wready_ff <= 1'b0;
			end
			if (do_write) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= mapped_w ? `BLGD_RESP_OKAY : `BLGD_RESP_SLVERR;
			end
			if (bvalid_ff && bready) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// plain registers; command bit is a one-cycle request
	always @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff      <= `BLGD_CFG_RST;
			rate_ff     <= `BLGD_RATE_RST;
			time_ff     <= `BLGD_TIME_RST;
			alarm_ff    <= `BLGD_ALARM_RST;
			show_cmd_ff <= 1'b0;
		end else begin
			show_cmd_ff <= do_write & (waddr_ff == `BLGD_CMD) & wstrb_ff[0]
			               & wdata_ff[`BLGD_CMD_SHOW];
			if (wr_cfg)
				cfg_ff <= cfg_new;
			if (do_write && waddr_ff == `BLGD_RATE)
				rate_ff <= merge(rate_ff, wdata_ff, wstrb_ff);
			if (do_write && waddr_ff == `BLGD_TIME)
				time_ff <= merge(time_ff, wdata_ff, wstrb_ff);
			if (do_write && waddr_ff == `BLGD_ALARM)
				alarm_ff <= merge(alarm_ff, wdata_ff, wstrb_ff);
		end
	end

	// per-segment thresholds; fixed tables lock out software writes
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_thr
			localparam [5:0] DADR = (gi < 4) ? `BLGD_DTHR : `BLGD_THR5;
			localparam [5:0] CADR = (gi < 4) ? `BLGD_CTHR : `BLGD_THR5;
			localparam integer DL = (gi < 4) ? gi : 0;
			localparam integer CL = (gi < 4) ? gi : 1;
			wire [7:0] dval = wdata_ff[DL*8 +: 8];
			wire [7:0] cval = wdata_ff[CL*8 +: 8];
			always @(posedge aclk) begin
				if (!aresetn) begin
					dsg_thr_ff[gi] <= thr_fixed(CFG_RST[1:0], gi);
					chg_thr_ff[gi] <= thr_fixed(CFG_RST[1:0], gi);
				end else if (reload) begin
					dsg_thr_ff[gi] <= thr_fixed(cfg_new[1:0], gi);
					chg_thr_ff[gi] <= thr_fixed(cfg_new[1:0], gi);
				end else begin
					if (user_wr && waddr_ff == DADR && wstrb_ff[DL])
						dsg_thr_ff[gi] <= (dval > `BLGD_PCT_MAX) ? `BLGD_PCT_MAX : dval;
					if (user_wr && waddr_ff == CADR && wstrb_ff[CL])
						chg_thr_ff[gi] <= (cval > `BLGD_PCT_MAX) ? `BLGD_PCT_MAX : cval;
				end
			end
		end
	endgenerate

	// read data selection
	always @* begin
		case ({araddr[5:2], 2'b00})
			`BLGD_CFG:   rd_mux = cfg_ff;
			`BLGD_CMD:   rd_mux = 32'h0000_0000;
			`BLGD_RATE:  rd_mux = rate_ff;
			`BLGD_TIME:  rd_mux = time_ff;
			`BLGD_ALARM: rd_mux = alarm_ff;
			`BLGD_DTHR:  rd_mux = {dsg_thr_ff[3], dsg_thr_ff[2], dsg_thr_ff[1], dsg_thr_ff[0]};
			`BLGD_CTHR:  rd_mux = {chg_thr_ff[3], chg_thr_ff[2], chg_thr_ff[1], chg_thr_ff[0]};
			`BLGD_THR5:  rd_mux = {16'h0000, chg_thr_ff[4], dsg_thr_ff[4]};
			`BLGD_STATE: rd_mux = {16'h0000, pf_rem_ff == 16'h0000, pin_lvl_ff, step_ff,
			                       state_ff, busy_ff, 3'h0, seg_ff};
			default:     rd_mux = 32'h0000_0000;
		endcase
	end

	// axi read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= `BLGD_RESP_OKAY;
		end else begin
			if (arvalid && arready_ff) begin
				arready_ff <= 1'b0;
				rvalid_ff  <= 1'b1;
				rdata_ff   <= rd_mux;
				rresp_ff   <= ({araddr[5:2], 2'b00} <= `BLGD_STATE) ?
				              `BLGD_RESP_OKAY : `BLGD_RESP_SLVERR;
			end
			if (rvalid_ff && rready) begin
				rvalid_ff  <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// pin sync; a level counts once second and third stages agree
	wire pin_fall = pin_lvl_ff & ~pin_s2_ff & ~pin_s3_ff;
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_ff  <= 1'b1;
			pin_s2_ff  <= 1'b1;
			pin_s3_ff  <= 1'b1;
			pin_lvl_ff <= 1'b1;
		end else begin
			pin_s1_ff <= display_request_pin;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			if (pin_s2_ff == pin_s3_ff)
				pin_lvl_ff <= pin_s3_ff;
		end
	end

	// millisecond tick shared by every timer
	always @(posedge aclk) begin
		if (!aresetn) begin
			ms_cnt_ff  <= 18'h00000;
			ms_tick_ff <= 1'b0;
		end else begin
			ms_tick_ff <= (ms_cnt_ff == MS_LAST);
			ms_cnt_ff  <= (ms_cnt_ff == MS_LAST) ? 18'h00000 : ms_cnt_ff + 18'h00001;
		end
	end

	// flash (0) and blink (1) phases, half period each; odd rates round down
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_phase
			wire [15:0] rate = rate_ff[gi*16 +: 16];
			wire [15:0] half = (rate[15:1] == 15'h0000) ? 16'h0001 : {1'b0, rate[15:1]};
			always @(posedge aclk) begin
				if (!aresetn) begin
					ph_cnt_ff[gi] <= 16'h0000;
					phase_ff[gi]  <= 1'b1;
				end else if (ms_tick_ff) begin
					if (ph_cnt_ff[gi] >= half - 16'h0001) begin
						ph_cnt_ff[gi] <= 16'h0000;
						phase_ff[gi]  <= ~phase_ff[gi];
					end else begin
						ph_cnt_ff[gi] <= ph_cnt_ff[gi] + 16'h0001;
					end
				end
			end
		end
	endgenerate

	// capacity pattern: compare, top segment, step mask
	wire [4:0] lit, top, stepm;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_seg
			wire [7:0] thr = discharging_flag ? dsg_thr_ff[gi] : chg_thr_ff[gi];
			assign lit[gi]   = (gi < nseg) & (pct >= thr);
			assign top[gi]   = lit[gi] & ~|(lit >> (gi + 1));
			assign stepm[gi] = (gi < step_ff);
		end
	endgenerate

	wire [7:0] alarm_lvl = discharging_flag ? alarm_ff[7:0] : alarm_ff[15:8];
	wire       low_alarm = (pct <= alarm_lvl);
	wire       rca_flash = cfg_ff[`BLGD_CFG_RCAEN] & remaining_capacity_alarm;
	wire       pf_show   = permanent_fail_flag & ~series;

	// pattern shown this cycle
	always @* begin
		if (discharging_flag)
			base = lit;
		else
			base = (lit & ~top) | (top & {5{blink_ph}});
		if (low_alarm || rca_flash)
			base = lit & {5{flash_ph}};
		if (pf_show)
			base = pf_pattern(cause_idx(fail_cause_word), flash_ph, blink_ph);
		case (state_ff)
			`BLGD_ST_STEP: shown = base & stepm;
			`BLGD_ST_HOLD: shown = base;
			`BLGD_ST_FAIL: shown = pf_pattern(cause_idx(pf_rem_ff), flash_ph, blink_ph);
			default:       shown = 5'h00;
		endcase
		if (uv_block)
			shown = 5'h00;
	end

	// activation sources and timer limits
	wire        keep_on  = cfg_ff[`BLGD_CFG_SHOW_WHILE_CHARGING] & charge_current_high;
	wire        pin_go   = pin_fall & (state_ff == `BLGD_ST_IDLE);
	wire        activate = show_cmd_ff | (first_ff & cfg_ff[`BLGD_CFG_SHOW_AFTER_RESET]) | pin_go | keep_on;
	wire [19:0] hold_ms  = {12'h000, time_ff[23:16]} * `BLGD_S_MS;
	wire [19:0] delay_ms = {4'h0, time_ff[15:0]};
	wire [19:0] pf_ms    = {hold_ms[18:0], 1'b0};
	wire        pf_go    = cfg_ff[`BLGD_CFG_PFEN] & ~series & pin_act_ff
	                       & (cfg_ff[`BLGD_CFG_PFNOHOLD] | pin_held_ff)
	                       & (fail_cause_word != 16'h0000);

	// display sequencer
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff    <= `BLGD_ST_IDLE;
			step_ff     <= 3'h0;
			tmr_ff      <= 20'h00000;
			pin_act_ff  <= 1'b0;
			pin_held_ff <= 1'b0;
			pf_rem_ff   <= 16'h0000;
			first_ff    <= 1'b1;
		end else begin
			first_ff <= 1'b0;
			if (pin_lvl_ff)
				pin_held_ff <= 1'b0;
			if (uv_block) begin
				state_ff <= `BLGD_ST_IDLE;
				step_ff  <= 3'h0;
			end else begin
				case (state_ff)
					`BLGD_ST_IDLE: begin
						if (activate) begin
							state_ff    <= `BLGD_ST_STEP;
							step_ff     <= 3'h1;
							tmr_ff      <= 20'h00000;
							pin_act_ff  <= pin_go;
							pin_held_ff <= pin_go;
						end
					end
					`BLGD_ST_STEP: begin
						if (step_ff >= nseg) begin
							state_ff <= `BLGD_ST_HOLD;
							tmr_ff   <= 20'h00000;
						end else if (tmr_ff >= delay_ms) begin
							step_ff <= step_ff + 3'h1;
							tmr_ff  <= 20'h00000;
						end else if (ms_tick_ff) begin
							tmr_ff <= tmr_ff + 20'h00001;
						end
					end
					`BLGD_ST_HOLD: begin
						if (keep_on) begin
							tmr_ff <= 20'h00000;
						end else if (tmr_ff >= hold_ms) begin
							tmr_ff <= 20'h00000;
							if (pf_go) begin
								state_ff  <= `BLGD_ST_FAIL;
								pf_rem_ff <= fail_cause_word;
							end else begin
								state_ff <= `BLGD_ST_IDLE;
								step_ff  <= 3'h0;
							end
						end else if (ms_tick_ff) begin
							tmr_ff <= tmr_ff + 20'h00001;
						end
					end
					`BLGD_ST_FAIL: begin
						if (pf_rem_ff == 16'h0000) begin
							state_ff <= `BLGD_ST_IDLE;
							step_ff  <= 3'h0;
						end else if (tmr_ff >= pf_ms) begin
							pf_rem_ff <= pf_rem_ff & (pf_rem_ff - 16'h0001);
							tmr_ff    <= 20'h00000;
						end else if (ms_tick_ff) begin
							tmr_ff <= tmr_ff + 20'h00001;
						end
					end
					default: state_ff <= `BLGD_ST_IDLE;
				endcase
			end
		end
	end

	// drive: parallel is the pattern, series shunts every dark node
	always @(posedge aclk) begin
		if (!aresetn) begin
			seg_ff  <= 5'h00;
			busy_ff <= 1'b0;
		end else begin
			seg_ff  <= series ? ~shown : shown;
			busy_ff <= (state_ff != `BLGD_ST_IDLE);
		end
	end

endmodule

// File: blgd_display_properties.sv
// concurrent checks on the led gauge display ports
`timescale 1ns/1ps
module blgd_display_properties (
	// clock and reset
	input wire        aclk,
	input wire        aresetn,
	// register bus handshakes
	input wire        awready,
	input wire        wready,
	input wire        bvalid,
	input wire        bready,
	input wire        arready,
	input wire        rvalid,
	input wire        rready,
	input wire [31:0] rdata,
	// safety flags and push-button
	input wire        cell_undervoltage_flag,
	input wire        pack_undervoltage_flag,
	input wire        display_request_pin,
	// display outputs
	input wire [4:0]  segment_drive,
	input wire        display_busy
);
	// single domain, clock and disable given once
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// blank means all off (parallel) or all shunted (series)
	wire uv   = cell_undervoltage_flag || pack_undervoltage_flag;
	wire dark = (segment_drive == 5'h00) || (segment_drive == 5'h1F);

	AST_B_STANDS: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped before bready");
	AST_R_STANDS: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data changed before rready");
	AST_B_LOCKS: assert property (bvalid |-> !awready && !wready)
		else $error("write channel open while response pending");
	AST_R_LOCKS: assert property (rvalid |-> !arready)
		else $error("read address open while data pending");
	AST_UV_IDLE: assert property (uv |-> ##[1:2] !display_busy)
		else $error("display still busy under undervoltage");
	AST_UV_DARK: assert property (uv [*3] |-> dark && !display_busy)
		else $error("segments lit under undervoltage");
	AST_PIN_WAKE: assert property ($fell(display_request_pin) && !display_busy && !uv
		|-> ##[1:10] display_busy)
		else $error("button press did not start display");
	AST_IDLE_DARK: assert property (!display_busy [*3] |-> dark)
		else $error("segments lit while idle");
endmodule

bind blgd_display blgd_display_properties u_blgd_display_properties (.*);

// File: blgd_led_panel.sv
// partner model: led segments and display push-button
`timescale 1ns/1ps
module blgd_led_panel (
	// clock
	input  wire       aclk,
	// button held down by the bench
	input  wire       press,
	// segment drive from the block
	input  wire [4:0] segment_drive,
	output wire       display_request_pin
);
	reg [4:0] lit_ff;

	// button to ground with pull-up: released pin reads high, held low as long as pressed
	assign display_request_pin = press ? 1'b0 : 1'b1;

	// last pattern, kept for waveform viewing only
	always @(posedge aclk) begin
		lit_ff <= segment_drive;
	end
endmodule

// File: blgd_display_test.sv
// self-checking bench for the led gauge display
`timescale 1ns/1ps
`include "blgd_consts.vh"
module blgd_display_test;
	reg         aclk = 1'b0, aresetn = 1'b0, press = 1'b0;
	reg  [5:0]  awaddr = 6'h00, araddr = 6'h00;
	reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	reg  [31:0] wdata = 32'h0;
	reg  [3:0]  wstrb = 4'hF;
	reg  [7:0]  relative_charge = 8'h32, absolute_charge = 8'h32;
	reg         discharging_flag = 1'b1, remaining_capacity_alarm = 1'b0;
	reg         permanent_fail_flag = 1'b0, charge_current_high = 1'b0;
	reg         cell_undervoltage_flag = 1'b0, pack_undervoltage_flag = 1'b0;
	reg  [15:0] fail_cause_word = 16'h0;
	wire        awready, wready, bvalid, arready, rvalid, display_request_pin, display_busy;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [4:0]  segment_drive;
	int         err_count = 0, checks_done = 0, i, n;
	reg  [15:0] rnd = 16'h7EDB;
	reg  [31:0] rd;
	reg  [1:0]  rs, c;
	reg  [4:0]  sa, so, e;
	reg  [7:0]  p;
	// charge mode table: {alarm flash enable, capacity alarm, discharging}
	reg  [2:0]  t_ctl [5] = '{3'h0, 3'h1, 3'h0, 3'h7, 3'h3};
	reg  [7:0]  t_pct [5] = '{8'h24, 8'h0F, 8'h08, 8'h5A, 8'h5A};
	reg  [4:0]  t_and [5] = '{5'h01, 5'h00, 5'h00, 5'h00, 5'h1F};
	reg  [4:0]  t_or  [5] = '{5'h03, 5'h01, 5'h01, 5'h1F, 5'h1F};

	// short ms so that hold seconds stay affordable
	blgd_display #(.MS_CYCLES(4)) u_blgd_display (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .relative_charge, .absolute_charge, .discharging_flag,
		.remaining_capacity_alarm, .permanent_fail_flag, .fail_cause_word,
		.cell_undervoltage_flag, .pack_undervoltage_flag, .charge_current_high,
		.display_request_pin, .segment_drive, .display_busy
	);
	blgd_led_panel u_blgd_led_panel (.aclk, .press, .segment_drive, .display_request_pin);

	// 250 mhz clock
	always #2 aclk = ~aclk;

	// random source, seed 32475
	function [15:0] lfsr(input [15:0] s);
		lfsr = s[0] ? (s >> 1) ^ 16'hB400 : s >> 1;
	endfunction
	// fixed-count pattern: three segments use 34/67, others even steps
	function [4:0] pat(input [1:0] cn, input [7:0] pc);
		pat = 5'h00;
		for (int k = 0; k < cn + 2; k++)
			pat[k] = pc >= ((cn == 1) ? (k == 0 ? 0 : k == 1 ? 8'h22 : 8'h43) : k * 100 / (cn + 2));
	endfunction
	// failure code {steady mask, seen mask}: blink/flash seen only, on steady
	function [9:0] pfx(input [4:0] code);
		reg [1:0] a, b;
		a = code < 9 ? code % 3 : (code - 9) % 3;
		b = code < 9 ? code / 3 : (code - 9) / 3;
		if (code < 9)
			pfx = {2'h0, 1'b0, a == 1, b == 1, 2'h0, 1'b1, a != 0, b != 0};
		else
			pfx = {2'h0, a == 1, 1'b0, b == 1, 2'h0, a != 0, 1'b1, b != 0};
	endfunction

	task chk(input [31:0] got, input [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// write: address and data offered together, each dropped when taken
	task axw(input [5:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task axr(input [5:0] a, output [31:0] d, output [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task wr(input [5:0] a, input [31:0] d);
		axw(a, d, 4'hF, rs);
	endtask
	// poll the state register, bounded
	task wait_st(input [1:0] st);
		rd = 32'h0;
		for (int k = 0; k < 400 && rd[10:9] !== st; k++) axr(`BLGD_STATE, rd, rs);
		chk(rd[10:9], st);
	endtask
	task show;
		wr(`BLGD_CMD, 32'h1);
		wait_st(2'h2);
	endtask
	// steady and seen masks over several flash and blink periods
	task win;
		sa = 5'h1F;
		so = 5'h00;
		repeat (64) begin
			@(posedge aclk);
			sa = sa & segment_drive;
			so = so | segment_drive;
		end
	endtask
	// undervoltage cuts any display short, saves hold time
	task blank;
		@(posedge aclk);
		{cell_undervoltage_flag, pack_undervoltage_flag} <= {~rnd[0], rnd[0]};
		repeat (4) @(posedge aclk);
		chk(display_busy, 0);
		chk(segment_drive == 5'h00 || segment_drive == 5'h1F, 1);
		{cell_undervoltage_flag, pack_undervoltage_flag} <= 2'b00;
		repeat (2) @(posedge aclk);
	endtask
	task stop_test;
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// hang guard, well above the expected run
	initial begin
		repeat (60000) @(posedge aclk);
		err_count++;
		stop_test;
	end

	// main sequence
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axr(`BLGD_CFG, rd, rs);
		chk(rd, `BLGD_CFG_RST);
		chk(display_busy, 1);
		axr(`BLGD_RATE, rd, rs);
		chk(rd, `BLGD_RATE_RST);
		axr(`BLGD_TIME, rd, rs);
		chk(rd, `BLGD_TIME_RST);
		blank;
		axr(6'h24, rd, rs);
		chk(rs, `BLGD_RESP_SLVERR);
		axw(6'h20, 32'h0, 4'hF, rs);
		chk(rs, `BLGD_RESP_SLVERR);
		// hold 1 s, step 2 ms, blink 8 ms, flash 4 ms; discharge alarm byte only to 20
		wr(`BLGD_TIME, 32'h0001_0002);
		wr(`BLGD_RATE, 32'h0008_0004);
		axw(`BLGD_ALARM, 32'h0000_1414, 4'h1, rs);
		axr(`BLGD_ALARM, rd, rs);
		chk(rd, 32'h0000_0A14);
		// fixed counts, random source and level; last pass in series drive
		for (i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			c = (i == 3) ? 2'h3 : i[1:0] + 2'h1;
			p = 8'h15 + rnd % 80;
			relative_charge <= rnd[8] ? 8'h05 : p;
			absolute_charge <= rnd[8] ? p : 8'h05;
			wr(`BLGD_CFG, {28'h0, rnd[8], i == 3, c});
			show;
			win;
			e = (i == 3) ? ~pat(c, p) : pat(c, p);
			chk(sa, e);
			chk(so, e);
			if (i == 0) begin
				n = 0;
				while (display_busy && n < 5000) begin
					@(posedge aclk);
					n++;
				end
				chk(n > 3800 && n < 4010, 1);
			end
			blank;
		end
		// blink, alarm flash both ways, capacity alarm with and without enable
		for (i = 0; i < 5; i++) begin
			discharging_flag <= t_ctl[i][0];
			remaining_capacity_alarm <= t_ctl[i][1];
			relative_charge <= t_pct[i];
			wr(`BLGD_CFG, {27'h0, t_ctl[i][2], 4'h3});
			show;
			win;
			chk(sa, t_and[i]);
			chk(so, t_or[i]);
			blank;
		end
		// failure code format, random single cause
		discharging_flag <= 1'b1;
		remaining_capacity_alarm <= 1'b0;
		relative_charge <= 8'h32;
		permanent_fail_flag <= 1'b1;
		for (i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			fail_cause_word <= 16'h0001 << rnd[3:0];
			show;
			win;
			rd = pfx(rnd[3:0] + 5'h01);
			chk(sa, rd[9:5]);
			chk(so, rd[4:0]);
			blank;
		end
		permanent_fail_flag <= 1'b0;
		// user thresholds; segment five keeps the five-count value
		relative_charge <= 8'h3C;
		wr(`BLGD_CFG, 32'h0);
		wr(`BLGD_DTHR, 32'hFF30_1000);
		axr(`BLGD_DTHR, rd, rs);
		chk(rd, 32'h6530_1000);
		show;
		win;
		chk(sa, 5'h07);
		blank;
		// button: short press without and with no-hold, then long press without no-hold
		fail_cause_word <= 16'h0003;
		for (i = 0; i < 3; i++) begin
			wr(`BLGD_CFG, 32'h83 | ((i & 1) << 8));
			press <= 1'b1;
			repeat (20) @(posedge aclk);
			chk(display_busy, 1);
			press <= (i == 2);
			wait_st(2'h2);
			repeat (4100) @(posedge aclk);
			axr(`BLGD_STATE, rd, rs);
			chk(rd[10:9], i ? 2'h3 : 2'h0);
			press <= 1'b0;
			blank;
		end
		// charging keeps the display up beyond the hold time
		wr(`BLGD_CFG, 32'h43);
		charge_current_high <= 1'b1;
		repeat (6000) @(posedge aclk);
		chk(display_busy, 1);
		charge_current_high <= 1'b0;
		blank;
		stop_test;
	end
endmodule
